// File: src/acs_sequencer.sv
// converter channel sequencer: mode control, channel stepping, registers
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  // converter side
  input  wire logic        trig_i,
  input  wire logic        conv_done_i,
  output logic             conv_start_o,
  output logic [2:0]       conv_chan_o,
  output logic             busy_o,
  output logic             paused_o
);

  // ==========================================================================
  // declarations
  acs_wr_t    wr;
  acs_rd_t    rd;

  logic [2:0] end_sel_ff;
  logic [2:0] nxt_end_sel;
  logic [2:0] start_sel_ff;
  logic [2:0] nxt_start_sel;
  acs_mode_t  mode_ff;
  acs_mode_t  nxt_mode;

  acs_state_t state_ff;
  acs_state_t nxt_state;
  logic [2:0] cur_ff;
  logic [2:0] nxt_cur;
  logic       go_ff;
  logic       nxt_go;
  logic       busy_ff;
  logic       nxt_busy;
  logic       paused_ff;
  logic       nxt_paused;

  logic       sw_start;
  logic       sw_stop;
  logic       start_req;
  logic       at_end;
  logic [2:0] next_ch;
  logic       single;

  // ==========================================================================
  // bus slave
  acs_wb_slave u_wb (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_i (wb_dat_i),
    .wb_sel_i (wb_sel_i),
    .wb_ack_o (wb_ack_o),
    .wb_dat_o (wb_dat_o),
    .rd_i     (rd),
    .wr_o     (wr)
  );

  // ==========================================================================
  // channel stepping
  acs_chan_step u_step (
    .cur_i    (cur_ff),
    .start_i  (start_sel_ff),
    .end_i    (end_sel_ff),
    .at_end_o (at_end),
    .next_o   (next_ch)
  );

  // ==========================================================================
  // read view
  always_comb
  begin
    rd.ctrl = 8'h00;
    rd.ctrl[ACS_END_LSB +: ACS_CH_W]    = end_sel_ff;
    // start field shows the live or last converted channel, never the
    // value just written
    rd.ctrl[ACS_START_LSB +: ACS_CH_W]  = cur_ff;
    rd.ctrl[ACS_MODE_LSB +: ACS_MODE_W] = mode_ff;
    rd.cmd = 8'h00;
    rd.cmd[ACS_CMD_BUSY_BIT]   = busy_ff;
    rd.cmd[ACS_CMD_PAUSED_BIT] = paused_ff;
  end

  // ==========================================================================
  // configuration registers
  always_comb
  begin
    nxt_end_sel   = end_sel_ff;
    nxt_start_sel = start_sel_ff;
    nxt_mode      = mode_ff;
    // writes while busy are the caller's fault and still land;
    if (wr.ctrl_we)
    begin
      nxt_end_sel   = wr.wdata[ACS_END_LSB +: ACS_CH_W];
      nxt_start_sel = wr.wdata[ACS_START_LSB +: ACS_CH_W];
      nxt_mode      = acs_mode_t'(wr.wdata[ACS_MODE_LSB +: ACS_MODE_W]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      end_sel_ff   <= ACS_RST_CH;
      start_sel_ff <= ACS_RST_CH;
      mode_ff      <= acs_mode_t'(ACS_RST_MODE);
    end
    else
    begin
      end_sel_ff   <= nxt_end_sel;
      start_sel_ff <= nxt_start_sel;
      mode_ff      <= nxt_mode;
    end
  end

  // ==========================================================================
  // sequencing state machine
  always_comb
  begin
    sw_start  = wr.cmd_we && wr.wdata[ACS_CMD_START_BIT];
    // forced stop wins over a simultaneous start; software must not
    // issue both at once anyway
    sw_stop   = wr.cmd_we && !wr.wdata[ACS_CMD_BUSY_BIT];
    start_req = sw_start || trig_i;
    single    = (mode_ff == ACS_MD_SINGLE1) || (mode_ff == ACS_MD_SINGLE2);

    nxt_state = state_ff;
    nxt_cur   = cur_ff;
    nxt_go    = 1'b0;

    if (sw_stop)
    begin
      nxt_state = ACS_ST_IDLE;
    end
    else
    begin
      unique case (state_ff)
        ACS_ST_IDLE:
        begin
          if (start_req)
          begin
            nxt_state = ACS_ST_RUN;
            nxt_cur   = start_sel_ff;
            nxt_go    = 1'b1;
          end
        end
        ACS_ST_RUN:
        begin
          if (start_req && (mode_ff == ACS_MD_SINGLE1))
          begin
            // only single mode 1 may be restarted mid-sequence
            nxt_cur = start_sel_ff;
            nxt_go  = 1'b1;
          end
          else if (conv_done_i)
          begin
            if (at_end && single)
            begin
              nxt_state = ACS_ST_IDLE;
            end
            else if (mode_ff == ACS_MD_PAUSE)
            begin
              // hold cur so reads show the channel just done
              nxt_state = ACS_ST_PAUSE;
            end
            else
            begin
              nxt_cur = next_ch;
              nxt_go  = 1'b1;
            end
          end
        end
        ACS_ST_PAUSE:
        begin
          if (sw_start)
          begin
            nxt_state = ACS_ST_RUN;
            nxt_cur   = next_ch;
            nxt_go    = 1'b1;
          end
        end
        default:
        begin
          nxt_state = ACS_ST_IDLE;
        end
      endcase
    end

    nxt_busy   = (nxt_state != ACS_ST_IDLE);
    nxt_paused = (nxt_state == ACS_ST_PAUSE);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff  <= ACS_ST_IDLE;
      cur_ff    <= ACS_RST_CH;
      go_ff     <= 1'b0;
      busy_ff   <= 1'b0;
      paused_ff <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      cur_ff    <= nxt_cur;
      go_ff     <= nxt_go;
      busy_ff   <= nxt_busy;
      paused_ff <= nxt_paused;
    end
  end

  // ==========================================================================
  // outputs
  assign conv_start_o = go_ff;
  assign conv_chan_o  = cur_ff;
  assign busy_o       = busy_ff;
  assign paused_o     = paused_ff;

endmodule

// File: src/acs_pkg.sv
// constants, types and helpers shared by the channel sequencer files
package acs_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] ACS_OFF_CTRL = 8'h00;
  localparam logic [7:0] ACS_OFF_CMD  = 8'h04;

  // ==========================================================================
  // control byte layout
  localparam int ACS_END_LSB   = 0;
  localparam int ACS_START_LSB = 3;
  localparam int ACS_MODE_LSB  = 6;
  localparam int ACS_CH_W      = 3;
  localparam int ACS_MODE_W    = 2;

  // command/status byte layout
  localparam int ACS_CMD_START_BIT  = 0;
  localparam int ACS_CMD_BUSY_BIT   = 1;
  localparam int ACS_CMD_PAUSED_BIT = 2;

  // ==========================================================================
  // reset values
  localparam logic [2:0] ACS_RST_CH   = 3'h0;
  localparam logic [1:0] ACS_RST_MODE = 2'h0;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    ACS_MD_SINGLE1 = 2'b00,
    ACS_MD_SINGLE2 = 2'b01,
    ACS_MD_CONT    = 2'b10,
    ACS_MD_PAUSE   = 2'b11
  } acs_mode_t;

  typedef enum logic [1:0] {
    ACS_ST_IDLE  = 2'b00,
    ACS_ST_RUN   = 2'b01,
    ACS_ST_PAUSE = 2'b10
  } acs_state_t;

  // register write strobes from the bus slave
  typedef struct packed {
    logic       ctrl_we;
    logic       cmd_we;
    logic [7:0] wdata;
  } acs_wr_t;

  // readable state handed to the bus slave
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] cmd;
  } acs_rd_t;

  // ==========================================================================
  // helpers
  function automatic logic [2:0] acs_inc_chan(input logic [2:0] ch);
    acs_inc_chan = ch + 3'h1;  // wraps seven to zero
  endfunction

endpackage

// File: src/acs_chan_step.sv
// next-channel computation for the sequencer
`timescale 1ns/1ps
module acs_chan_step
  import acs_pkg::*;
(
  // channel state
  input  wire logic [2:0] cur_i,
  input  wire logic [2:0] start_i,
  input  wire logic [2:0] end_i,
  // results
  output logic       at_end_o,
  output logic [2:0] next_o
);

  always_comb
  begin
    at_end_o = (cur_i == end_i);
    // modulo-eight step covers both the ascending and the wrapped
    // sequence
    if (at_end_o)
    begin
      next_o = start_i;
    end
    else
    begin
      next_o = acs_inc_chan(cur_i);
    end
  end

endmodule

// File: src/acs_wb_slave.sv
// classic wishbone slave front end for the sequencer registers
`timescale 1ns/1ps
module acs_wb_slave
  import acs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  // register side
  input  wire acs_rd_t     rd_i,
  output acs_wr_t          wr_o
);

  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic        hit_ctrl;
  logic        hit_cmd;
  logic        commit;

  // ==========================================================================
  // decode and answer
  always_comb
  begin
    hit_ctrl = (wb_adr_i == ACS_OFF_CTRL);
    hit_cmd  = (wb_adr_i == ACS_OFF_CMD);
    // one wait state; ack drops the cycle after it was given
    nxt_ack  = wb_cyc_i && wb_stb_i && !ack_ff;
    nxt_rdat = rdat_ff;
    if (nxt_ack)
    begin
      // unmapped addresses still answer, with zero data
      nxt_rdat = 32'h0000_0000;
      if (hit_ctrl)
      begin
        nxt_rdat = {24'h00_0000, rd_i.ctrl};
      end
      else if (hit_cmd)
      begin
        nxt_rdat = {24'h00_0000, rd_i.cmd};
      end
    end
    // write lands on the edge at which the master sees ack
    commit        = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && wb_sel_i[0];
    wr_o.ctrl_we  = commit && hit_ctrl;
    wr_o.cmd_we   = commit && hit_cmd;
    wr_o.wdata    = wb_dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

endmodule

// File: verification/acs_sequencer_properties.sv
// concurrent checks on the channel sequencer top ports
`timescale 1ns/1ps
module acs_sequencer_properties
  import acs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_ack_o,
  input  wire logic [31:0] wb_dat_o,
  // converter side
  input  wire logic        trig_i,
  input  wire logic        conv_done_i,
  input  wire logic        conv_start_o,
  input  wire logic [2:0]  conv_chan_o,
  input  wire logic        busy_o,
  input  wire logic        paused_o
);
  // ==========================================================
  // shadow of the written control byte
  logic [7:0] cfg_ff;
  logic [7:0] nxt_cfg;
  logic       run;

  always_comb
  begin
    nxt_cfg = cfg_ff;
    if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
        && wb_adr_i == ACS_OFF_CTRL)
    begin
      nxt_cfg = wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i)
    cfg_ff <= rst_i ? 8'h00 : nxt_cfg;

  assign run = busy_o && !paused_o && conv_done_i;

  // ==========================================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_one:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_wait:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_start_idle:
    assert property (trig_i && !busy_o |=> conv_start_o
                     && conv_chan_o == cfg_ff[5:3])
    else $error("trigger did not start at start channel");
  a_single_step:
    assert property (run && !cfg_ff[7] && conv_chan_o != cfg_ff[2:0]
      |=> conv_start_o && conv_chan_o == $past(conv_chan_o) + 3'h1)
    else $error("single mode step wrong");
  a_single_end:
    assert property (run && !cfg_ff[7] && conv_chan_o == cfg_ff[2:0]
      |=> !busy_o && $stable(conv_chan_o))
    else $error("single mode did not stop at end");
  a_cont_loop:
    assert property (run && cfg_ff[7:6] == ACS_MD_CONT |=> conv_start_o
      && conv_chan_o == ($past(conv_chan_o) == cfg_ff[2:0] ?
      cfg_ff[5:3] : $past(conv_chan_o) + 3'h1))
    else $error("continuous step wrong");
  a_pause_hold:
    assert property (run && cfg_ff[7:6] == ACS_MD_PAUSE
      |=> paused_o && !conv_start_o && $stable(conv_chan_o))
    else $error("pause mode did not hold");
  a_pause_resume:
    assert property (paused_o && wb_ack_o && wb_cyc_i && wb_stb_i
      && wb_we_i && wb_sel_i[0] && wb_adr_i == ACS_OFF_CMD
      && wb_dat_i[0] && wb_dat_i[1] |=> conv_start_o && !paused_o)
    else $error("software start did not resume pause");
  a_chan_hold:
    assert property (!conv_start_o |-> $stable(conv_chan_o))
    else $error("channel moved without start");
  a_flag_link:
    assert property (paused_o || conv_start_o |-> busy_o)
    else $error("paused or start without busy");
endmodule

bind acs_sequencer acs_sequencer_properties u_prop (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_i, .wb_sel_i, .wb_ack_o, .wb_dat_o, .trig_i,
  .conv_done_i, .conv_start_o, .conv_chan_o, .busy_o, .paused_o
);

// File: verification/acs_sequencer_tb.sv
// self-checking bench for the channel sequencer
`timescale 1ns/1ps
module acs_sequencer_tb
  import acs_pkg::*;
;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0]  wb_sel_i;
  logic        wb_ack_o;
  logic [31:0] wb_dat_o;
  logic        trig_i;
  logic        conv_done_i;
  logic        conv_start_o;
  logic [2:0]  conv_chan_o;
  logic        busy_o;
  logic        paused_o;
  logic [31:0] rdata;
  int          n_errors;
  int          check_count;

  acs_sequencer DUT (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_ack_o, .wb_dat_o, .trig_i,
    .conv_done_i, .conv_start_o, .conv_chan_o, .busy_o, .paused_o
  );

  // ==========================================================
  // tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // waits on ack, never assumes the latency
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [7:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h00_0000, dat};
    // ack and data are read at the rising edge, before that edge updates
    // them, so this is the value the slave presents during the ack cycle
    repeat (20)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1)
        break;
    end
    if (wb_ack_o !== 1'b1)
    begin
      n_errors++;
      $display("unexpected at %0t: no ack", $time);
      test_done();
    end
    rdata = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    wb(1'b0, adr, 8'h00);
    cmp(rdata, {24'h00_0000, exp});
  endtask

  // one channel: check it is running, then report it finished
  task automatic step(input logic [2:0] ch);
    @(negedge clk_i);
    cmp({busy_o, conv_chan_o}, {1'b1, ch});
    @(posedge clk_i);
    conv_done_i <= 1'b1;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
  endtask

  task automatic stat(input logic [1:0] s);
    @(negedge clk_i);
    cmp({busy_o, paused_o}, s);
  endtask

  task automatic trig();
    @(posedge clk_i);
    trig_i <= 1'b1;
    @(posedge clk_i);
    trig_i <= 1'b0;
  endtask

  // ==========================================================
  // clock and main sequence
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial
  begin
    n_errors = 0;
    check_count = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, trig_i, conv_done_i} = 5'h00;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'hF;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ACS_OFF_CTRL, 8'h00);
    rd(ACS_OFF_CMD, 8'h00);
    rd(8'h10, 8'h00);
    $display("test reset finished");
    // channel fields are written whether idle or busy
    wb(1'b1, ACS_OFF_CTRL, 8'h15);
    rd(ACS_OFF_CTRL, 8'h05);
    // start with bit 1 set, since bit 1 clear is a forced stop
    wb(1'b1, ACS_OFF_CMD, 8'h03);
    rd(ACS_OFF_CTRL, 8'h15);
    step(3'h2);
    step(3'h3);
    step(3'h4);
    step(3'h5);
    stat(2'b00);
    $display("test ascending finished");
    wb(1'b1, ACS_OFF_CTRL, 8'h5B);
    trig();
    step(3'h3);
    stat(2'b00);
    $display("test single channel finished");
    wb(1'b1, ACS_OFF_CTRL, 8'hB1);
    wb(1'b1, ACS_OFF_CMD, 8'h03);
    step(3'h6);
    step(3'h7);
    step(3'h0);
    step(3'h1);
    step(3'h6);
    wb(1'b1, ACS_OFF_CMD, 8'h00);
    stat(2'b00);
    $display("test wrap finished");
    wb(1'b1, ACS_OFF_CTRL, 8'h02);
    wb(1'b1, ACS_OFF_CMD, 8'h03);
    step(3'h0);
    // single mode 1 restarts from the start channel mid-sequence
    trig();
    step(3'h0);
    step(3'h1);
    step(3'h2);
    stat(2'b00);
    $display("test restart finished");
    wb(1'b1, ACS_OFF_CTRL, 8'hCA);
    wb(1'b1, ACS_OFF_CMD, 8'h03);
    step(3'h1);
    stat(2'b11);
    rd(ACS_OFF_CTRL, 8'hCA);
    rd(ACS_OFF_CMD, 8'h06);
    trig();
    stat(2'b11);
    wb(1'b1, ACS_OFF_CMD, 8'h03);
    step(3'h2);
    wb(1'b1, ACS_OFF_CMD, 8'h03);
    step(3'h1);
    wb(1'b1, ACS_OFF_CMD, 8'h00);
    stat(2'b00);
    $display("test pause finished");
    // reset in the middle of a running sequence
    wb(1'b1, ACS_OFF_CMD, 8'h03);
    stat(2'b10);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    stat(2'b00);
    rd(ACS_OFF_CTRL, 8'h00);
    $display("test reset in run finished");
    test_done();
  end
endmodule
